// ### rtc_alarm_cfg.svh
// Register map, field positions and timing counts of the RTC alarm block
`ifndef RTC_ALARM_CFG_SVH
`define RTC_ALARM_CFG_SVH

// Register bus
`define ADDR_W            4
`define DATA_W            32
`define OFS_ALARM_CONTROL 4'h0
`define OFS_ALARM_TIME    4'h4

// Alarm control fields
`define CTL_ENABLE_BIT    15
`define CTL_CHIME_BIT     14
`define CTL_PIV_BIT       13
`define CTL_SYNC_BIT      12
`define CTL_IVL_HI        11
`define CTL_IVL_LO        8
`define CTL_RPT_HI        7
`define CTL_RPT_LO        0

// Alarm time fields
`define TIM_HR_T_HI       29
`define TIM_HR_T_LO       28
`define TIM_HR_O_HI       27
`define TIM_HR_O_LO       24
`define TIM_MN_T_HI       22
`define TIM_MN_T_LO       20
`define TIM_MN_O_HI       19
`define TIM_MN_O_LO       16
`define TIM_SC_T_HI       14
`define TIM_SC_T_LO       12
`define TIM_SC_O_HI       11
`define TIM_SC_O_LO       8

// Reset values and counter limits
`define RPT_RESET         8'h00
`define RPT_ZERO          8'h00
`define RPT_MAX           8'hff
`define IVL_RESET         4'h0
`define BIT_RESET         1'b0

// RTC ticks per half second, and guard before rollover
`define HALF_SEC_TICKS    16384
`define SYNC_GUARD_TICKS  32

`endif

// ### rtc_alarm_pkg.sv
// Types shared by the RTC alarm block
package rtc_alarm_pkg;

  // Alarm repeat interval codes
  typedef enum logic [3:0] {
    IVL_HALF_SEC = 4'h0,
    IVL_SECOND   = 4'h1,
    IVL_TEN_SEC  = 4'h2,
    IVL_MINUTE   = 4'h3,
    IVL_TEN_MIN  = 4'h4,
    IVL_HOUR     = 4'h5,
    IVL_DAY      = 4'h6,
    IVL_WEEK     = 4'h7,
    IVL_MONTH    = 4'h8,
    IVL_YEAR     = 4'h9
  } interval_e;

  typedef logic [7:0] repeat_t;

endpackage

// ### rtc_tick_sync.sv
// Oscillator pin synchroniser and rising-edge tick
`timescale 1ns/1ps
module rtc_tick_sync (
  input  wire logic i_core_clk,
  input  wire logic i_rst_n,
  input  wire logic i_rtc_osc,
  output logic      o_rtc_tick
);

  logic stage1;
  logic stage2;
  logic stage3;
  logic stable;

  // Three-stage pin synchroniser
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
    end else begin
      stage1 <= i_rtc_osc;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // Level accepted once the last two stages agree; tick on its rise
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      stable     <= 1'b0;
      o_rtc_tick <= 1'b0;
    end else begin
      if (stage2 == stage3) begin
        stable <= stage3;
      end
      o_rtc_tick <= (stage2 == stage3) && stage3 && !stable;
    end
  end

endmodule

// ### alarm_match.sv
// Masked compare of running time with the alarm time
`timescale 1ns/1ps
module alarm_match (
  input  wire logic                   i_core_clk,
  input  wire logic                   i_rst_n,
  input  wire logic                   i_armed,
  input  wire logic                   i_half_edge,
  input  wire logic                   i_sec_edge,
  input  rtc_alarm_pkg::interval_e    i_interval,
  input  wire logic [7:0]             i_cur_hms_hi,
  input  wire logic [15:0]            i_cur_hms_lo,
  input  wire logic [7:0]             i_al_hms_hi,
  input  wire logic [15:0]            i_al_hms_lo,
  input  wire logic                   i_weekday_match,
  input  wire logic                   i_day_match,
  input  wire logic                   i_month_match,
  output logic                        o_hit
);

  logic so;
  logic st;
  logic mo;
  logic mt;
  logic hr;
  logic next_hit;

  // Digit compares: lo = {min_t,min_o,sec_t,sec_o}, hi = hours
  assign so = i_cur_hms_lo[3:0] == i_al_hms_lo[3:0];
  assign st = i_cur_hms_lo[7:4] == i_al_hms_lo[7:4];
  assign mo = i_cur_hms_lo[11:8] == i_al_hms_lo[11:8];
  assign mt = i_cur_hms_lo[15:12] == i_al_hms_lo[15:12];
  assign hr = i_cur_hms_hi == i_al_hms_hi;

  // Fields left unmasked by the interval must match
  always_comb begin
    case (i_interval)
      rtc_alarm_pkg::IVL_HALF_SEC: next_hit = i_half_edge;
      rtc_alarm_pkg::IVL_SECOND:   next_hit = i_sec_edge;
      rtc_alarm_pkg::IVL_TEN_SEC:  next_hit = i_sec_edge && so;
      rtc_alarm_pkg::IVL_MINUTE:   next_hit = i_sec_edge && so && st;
      rtc_alarm_pkg::IVL_TEN_MIN:  next_hit = i_sec_edge && so && st && mo;
      rtc_alarm_pkg::IVL_HOUR:     next_hit = i_sec_edge && so && st && mo && mt;
      rtc_alarm_pkg::IVL_DAY:      next_hit = i_sec_edge && so && st && mo && mt && hr;
      rtc_alarm_pkg::IVL_WEEK:     next_hit = i_sec_edge && so && st && mo && mt && hr && i_weekday_match;
      rtc_alarm_pkg::IVL_MONTH:    next_hit = i_sec_edge && so && st && mo && mt && hr && i_day_match;
      rtc_alarm_pkg::IVL_YEAR:     next_hit = i_sec_edge && so && st && mo && mt && hr && i_day_match
                                              && i_month_match;
      default:                     next_hit = 1'b0;
    endcase
  end

  // Registered hit, only while armed
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_hit <= 1'b0;
    end else begin
      o_hit <= i_armed && next_hit;
    end
  end

endmodule

// ### rtc_alarm_control.sv
// RTC alarm control: registers, prescaler, sync flag, repeat and pulse
//
// What this block does
// - Control bit 15 arms the alarm when written one, disarms when zero.
// - Chime on: repeat counter wraps from zero to its maximum.
// - Chime off: repeat counter stops at zero.
// - Disarmed: pulse initial value bit 13 is writable and sets pulse level.
// - Armed: bit 13 ignores writes and reads back the live pulse level.
// - Bit 12 flags that repeat count or enable may change near rollover.
// - Flag clears only when more than 32 RTC ticks from rollover.
// - Interval codes 0 to 7: half second up to weekly.
// - Code 8 monthly, code 9 yearly; Feb 29 fires every fourth year.
// - Event at count zero with chime off clears the enable bit.
// - Alarm control resets only on power-on reset.
// - Hours as BCD: tens at bits 29-28, ones at bits 27-24.
// - Minutes as BCD: tens at bits 22-20, ones at bits 19-16.
// - Seconds as BCD: tens at bits 14-12, ones at bits 11-8.
// - Time register bits 7-0, 31-30, 23 and 15 read zero.
// - Control register bits 31-16 read zero.
//
// Local design decisions: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`include "rtc_alarm_cfg.svh"
module rtc_alarm_control #(
  parameter int HALF_SEC_TICKS = `HALF_SEC_TICKS
) (
  input  wire logic               i_core_clk,
  input  wire logic               i_rst_n,
  input  wire logic               i_sys_rst_n,
  input  wire logic               i_rtc_osc,
  input  wire logic               i_clock_module_on,
  input  wire logic [1:0]         i_cur_hour_tens,
  input  wire logic [3:0]         i_cur_hour_ones,
  input  wire logic [2:0]         i_cur_minute_tens,
  input  wire logic [3:0]         i_cur_minute_ones,
  input  wire logic [2:0]         i_cur_second_tens,
  input  wire logic [3:0]         i_cur_second_ones,
  input  wire logic               i_weekday_match,
  input  wire logic               i_day_match,
  input  wire logic               i_month_match,
  input  wire logic [`ADDR_W-1:0] i_addr,
  input  wire logic [`DATA_W-1:0] i_wdata,
  input  wire logic               i_wr,
  input  wire logic               i_rd,
  output logic      [`DATA_W-1:0] o_rd_data,
  output logic                    o_alarm_pulse,
  output logic                    o_alarm_event,
  output logic                    o_rollover_sync_flag,
  output logic                    o_half_sec_tick
);

  localparam int CW = $clog2(HALF_SEC_TICKS);
  localparam logic [CW-1:0] PRESC_LAST = CW'(HALF_SEC_TICKS - 1);
  localparam logic [CW-1:0] GUARD = CW'(`SYNC_GUARD_TICKS);

  // Alarm control fields
  logic                     alarm_enable;
  logic                     chime_enable;
  logic                     pulse_initial_value;
  rtc_alarm_pkg::interval_e alarm_interval_select;
  rtc_alarm_pkg::repeat_t   repeat_count;

  // Alarm time fields
  logic [1:0] hour_tens;
  logic [3:0] hour_ones;
  logic [2:0] minute_tens;
  logic [3:0] minute_ones;
  logic [2:0] second_tens;
  logic [3:0] second_ones;

  // Time base
  logic          rtc_tick;
  logic [CW-1:0] presc;
  logic          half_phase;
  logic          half_edge;
  logic          sec_edge;
  logic [CW-1:0] dist_to_roll;
  logic          hit;

  // Bus decode
  logic wr_ctl;
  logic wr_tim;
  logic wr_piv;
  logic rd_ctl;
  logic rd_tim;

  // Event effects, rollover window and next read word
  logic                   wrap_now;
  logic                   near_roll;
  logic                   last_event;
  rtc_alarm_pkg::repeat_t next_repeat;
  logic [`DATA_W-1:0]     next_rd_data;

  // Address compare, shared by write and read paths
  function automatic logic addr_is(input logic [`ADDR_W-1:0] a,
                                   input logic [`ADDR_W-1:0] ofs);
    addr_is = (a == ofs);
  endfunction

  assign wr_ctl = i_wr && addr_is(i_addr, `OFS_ALARM_CONTROL);
  assign wr_tim = i_wr && addr_is(i_addr, `OFS_ALARM_TIME);

  // Read strobes per register
  assign rd_ctl = i_rd && addr_is(i_addr, `OFS_ALARM_CONTROL);
  assign rd_tim = i_rd && addr_is(i_addr, `OFS_ALARM_TIME);

  // Pulse initial value is locked while armed
  assign wr_piv = wr_ctl && !alarm_enable;

  // Oscillator pin to a core-clock tick enable
  rtc_tick_sync u_tick (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_rtc_osc  (i_rtc_osc),
    .o_rtc_tick (rtc_tick)
  );

  // Half-second prescaler, runs while the clock module is on
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      presc      <= '0;
      half_phase <= 1'b0;
    end else if (rtc_tick && i_clock_module_on) begin
      if (presc == PRESC_LAST) begin
        presc      <= '0;
        half_phase <= !half_phase;
      end else begin
        presc <= presc + CW'(1);
      end
    end
  end

  // Tick on which the prescaler wraps
  assign wrap_now = rtc_tick && i_clock_module_on && (presc == PRESC_LAST);

  // One-cycle rollover strobes; full second on second half rollover
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      half_edge <= 1'b0;
      sec_edge  <= 1'b0;
    end else begin
      half_edge <= wrap_now;
      sec_edge  <= wrap_now && half_phase;
    end
  end

  // Output copy of the half-second strobe
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_half_sec_tick <= 1'b0;
    end else begin
      o_half_sec_tick <= wrap_now;
    end
  end

  // Distance in RTC ticks to the next half-second rollover
  assign dist_to_roll = PRESC_LAST - presc;

  // Inside the guard window a read may race a rollover
  assign near_roll = (dist_to_roll <= GUARD);

  // Sync flag high inside the guard window before rollover
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rollover_sync_flag <= 1'b0;
    end else begin
      o_rollover_sync_flag <= near_roll;
    end
  end

  // Masked compare of running time against the alarm time
  alarm_match u_match (
    .i_core_clk      (i_core_clk),
    .i_rst_n         (i_rst_n),
    .i_armed         (alarm_enable),
    .i_half_edge     (half_edge),
    .i_sec_edge      (sec_edge),
    .i_interval      (alarm_interval_select),
    .i_cur_hms_hi    ({2'b00, i_cur_hour_tens, i_cur_hour_ones}),
    .i_cur_hms_lo    ({1'b0, i_cur_minute_tens, i_cur_minute_ones,
                       1'b0, i_cur_second_tens, i_cur_second_ones}),
    .i_al_hms_hi     ({2'b00, hour_tens, hour_ones}),
    .i_al_hms_lo     ({1'b0, minute_tens, minute_ones,
                       1'b0, second_tens, second_ones}),
    .i_weekday_match (i_weekday_match),
    .i_day_match     (i_day_match),
    .i_month_match   (i_month_match),
    .o_hit           (hit)
  );

  // Event on the last repeat with chime off ends the alarm
  assign last_event = hit && (repeat_count == `RPT_ZERO) && !chime_enable;

  // Alarm enable: software write wins, event at count zero clears
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      alarm_enable <= `BIT_RESET;
    end else if (wr_ctl) begin
      alarm_enable <= i_wdata[`CTL_ENABLE_BIT];
    end else if (last_event) begin
      alarm_enable <= 1'b0;
    end
  end

  // Chime is a plain software field
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      chime_enable <= `BIT_RESET;
    end else if (wr_ctl) begin
      chime_enable <= i_wdata[`CTL_CHIME_BIT];
    end
  end

  // Interval select; reserved codes are stored but never match
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      alarm_interval_select <= rtc_alarm_pkg::interval_e'(`IVL_RESET);
    end else if (wr_ctl) begin
      alarm_interval_select <= rtc_alarm_pkg::interval_e'(i_wdata[`CTL_IVL_HI:`CTL_IVL_LO]);
    end
  end

  // Pulse initial value only accepts writes while disarmed
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pulse_initial_value <= `BIT_RESET;
    end else if (wr_piv) begin
      pulse_initial_value <= i_wdata[`CTL_PIV_BIT];
    end
  end

  // Count after an event: step down, wrap with chime, else hold at zero
  always_comb begin
    if (repeat_count != `RPT_ZERO) begin
      next_repeat = repeat_count - 8'h01;
    end else if (chime_enable) begin
      next_repeat = `RPT_MAX;
    end else begin
      next_repeat = `RPT_ZERO;
    end
  end

  // Repeat counter: write loads, event steps
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      repeat_count <= `RPT_RESET;
    end else if (wr_ctl) begin
      repeat_count <= i_wdata[`CTL_RPT_HI:`CTL_RPT_LO];
    end else if (hit) begin
      repeat_count <= next_repeat;
    end
  end

  // Pulse level follows the initial value while disarmed, toggles on events
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_alarm_pulse <= `BIT_RESET;
    end else if (!alarm_enable) begin
      o_alarm_pulse <= pulse_initial_value;
    end else if (hit) begin
      o_alarm_pulse <= !o_alarm_pulse;
    end
  end

  // One-cycle alarm event strobe
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_alarm_event <= 1'b0;
    end else begin
      o_alarm_event <= hit;
    end
  end

  // Alarm time register, power-on reset only
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hour_tens   <= '0;
      hour_ones   <= '0;
      minute_tens <= '0;
      minute_ones <= '0;
      second_tens <= '0;
      second_ones <= '0;
    end else if (wr_tim) begin
      hour_tens   <= i_wdata[`TIM_HR_T_HI:`TIM_HR_T_LO];
      hour_ones   <= i_wdata[`TIM_HR_O_HI:`TIM_HR_O_LO];
      minute_tens <= i_wdata[`TIM_MN_T_HI:`TIM_MN_T_LO];
      minute_ones <= i_wdata[`TIM_MN_O_HI:`TIM_MN_O_LO];
      second_tens <= i_wdata[`TIM_SC_T_HI:`TIM_SC_T_LO];
      second_ones <= i_wdata[`TIM_SC_O_HI:`TIM_SC_O_LO];
    end
  end

  // Control read word; upper half stays zero
  function automatic logic [`DATA_W-1:0] ctl_word();
    logic [`DATA_W-1:0] w;
    w = '0;
    w[`CTL_ENABLE_BIT] = alarm_enable;
    w[`CTL_CHIME_BIT] = chime_enable;
    w[`CTL_PIV_BIT] = alarm_enable ? o_alarm_pulse : pulse_initial_value;
    w[`CTL_SYNC_BIT] = o_rollover_sync_flag;
    w[`CTL_IVL_HI:`CTL_IVL_LO] = alarm_interval_select;
    w[`CTL_RPT_HI:`CTL_RPT_LO] = repeat_count;
    ctl_word = w;
  endfunction

  // Time read word; unused bits stay zero
  function automatic logic [`DATA_W-1:0] tim_word();
    logic [`DATA_W-1:0] w;
    w = '0;
    w[`TIM_HR_T_HI:`TIM_HR_T_LO] = hour_tens;
    w[`TIM_HR_O_HI:`TIM_HR_O_LO] = hour_ones;
    w[`TIM_MN_T_HI:`TIM_MN_T_LO] = minute_tens;
    w[`TIM_MN_O_HI:`TIM_MN_O_LO] = minute_ones;
    w[`TIM_SC_T_HI:`TIM_SC_T_LO] = second_tens;
    w[`TIM_SC_O_HI:`TIM_SC_O_LO] = second_ones;
    tim_word = w;
  endfunction

  // Read word picked by the strobed address; unmapped reads give zero
  always_comb begin
    if (rd_ctl) begin
      next_rd_data = ctl_word();
    end else if (rd_tim) begin
      next_rd_data = tim_word();
    end else begin
      next_rd_data = '0;
    end
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rd_data <= '0;
    end else if (!i_sys_rst_n) begin
      o_rd_data <= '0;
    end else begin
      o_rd_data <= next_rd_data;
    end
  end

endmodule

// ### rtc_alarm_control_assertions.sv
// Port checks for the RTC alarm control block
`timescale 1ns/1ps
`include "rtc_alarm_cfg.svh"
module rtc_alarm_control_checker (
  input wire logic               i_core_clk,
  input wire logic               i_rst_n,
  input wire logic [`ADDR_W-1:0] i_addr,
  input wire logic               i_rd,
  input wire logic [`DATA_W-1:0] o_rd_data,
  input wire logic               o_alarm_pulse,
  input wire logic               o_alarm_event,
  input wire logic               o_rollover_sync_flag,
  input wire logic               o_half_sec_tick
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  // Read data only in the cycle after a read strobe
  property p_rd_idle;
    !$past(i_rd) |-> o_rd_data == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero outside read");
  // Control upper half reads zero
  property p_ctl_hi;
    $past(i_rd) && $past(i_addr) == 4'h0 |-> o_rd_data[31:16] == 16'h0;
  endproperty
  a_ctl_hi: assert property (p_ctl_hi) else $error("control upper bits not zero");
  // Unused time bits read zero
  property p_tim_gaps;
    $past(i_rd) && $past(i_addr) == 4'h4 |->
      o_rd_data[7:0] == 8'h0 && o_rd_data[31:30] == 2'h0 && !o_rd_data[23] && !o_rd_data[15];
  endproperty
  a_tim_gaps: assert property (p_tim_gaps) else $error("time gap bits not zero");
  // Unmapped reads return zero
  property p_unmapped;
    $past(i_rd) && $past(i_addr) != 4'h0 && $past(i_addr) != 4'h4 |-> o_rd_data == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  // Each event flips the pulse level
  property p_ev_toggle;
    o_alarm_event |-> o_alarm_pulse != $past(o_alarm_pulse);
  endproperty
  a_ev_toggle: assert property (p_ev_toggle) else $error("pulse not toggled by event");
  // Events only two cycles after a half-second boundary
  property p_ev_boundary;
    o_alarm_event |-> $past(o_half_sec_tick, 2);
  endproperty
  a_ev_boundary: assert property (p_ev_boundary) else $error("event off boundary");
  // Half-second strobe is a lone pulse
  property p_tick_single;
    o_half_sec_tick |=> !o_half_sec_tick [*8];
  endproperty
  a_tick_single: assert property (p_tick_single) else $error("half tick too long");
  // Flag cleared the cycle after the rollover strobe
  property p_sync_clear;
    o_half_sec_tick |=> !o_rollover_sync_flag;
  endproperty
  a_sync_clear: assert property (p_sync_clear) else $error("sync flag set after rollover");
  // Flag stood high just before the rollover
  property p_sync_set;
    $rose(o_half_sec_tick) |-> $past(o_rollover_sync_flag) && $past(o_rollover_sync_flag, 2);
  endproperty
  a_sync_set: assert property (p_sync_set) else $error("sync flag low near rollover");
endmodule

bind rtc_alarm_control rtc_alarm_control_checker chk (
  .i_core_clk          (i_core_clk),
  .i_rst_n             (i_rst_n),
  .i_addr              (i_addr),
  .i_rd                (i_rd),
  .o_rd_data           (o_rd_data),
  .o_alarm_pulse       (o_alarm_pulse),
  .o_alarm_event       (o_alarm_event),
  .o_rollover_sync_flag(o_rollover_sync_flag),
  .o_half_sec_tick     (o_half_sec_tick)
);

// ### rtc_alarm_control_bench.sv
// Register-level testbench for the RTC alarm control block
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin errors++; \
  $display("BAD %s exp %h got %h", nm, exp, got); end end
module rtc_alarm_control_bench;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        sys_rst_n = 1'b1;
  logic [2:0]  osc_div = 3'h0;
  logic        on = 1'b0;
  logic [3:0]  sec_ones = 4'h0;
  logic        wk_match = 1'b1;
  logic        day_match = 1'b1;
  logic        mon_match = 1'b1;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [31:0] rd_data;
  logic        pulse, ev, sync, htick;
  logic [31:0] v;
  int          errors = 0;
  int          n_compared = 0;
  int          n_ev = 0;
  int          want;

  rtc_alarm_control #(.HALF_SEC_TICKS(64)) dut (
    .i_core_clk(clk), .i_rst_n(rst_n), .i_sys_rst_n(sys_rst_n), .i_rtc_osc(osc_div[2]),
    .i_clock_module_on(on), .i_cur_hour_tens(2'h0), .i_cur_hour_ones(4'h0),
    .i_cur_minute_tens(3'h0), .i_cur_minute_ones(4'h0), .i_cur_second_tens(3'h0),
    .i_cur_second_ones(sec_ones), .i_weekday_match(wk_match), .i_day_match(day_match),
    .i_month_match(mon_match), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rd_data(rd_data), .o_alarm_pulse(pulse), .o_alarm_event(ev),
    .o_rollover_sync_flag(sync), .o_half_sec_tick(htick)
  );

  // 200 MHz core clock
  always #2.5 clk = ~clk;
  // Oscillator at one eighth of the core rate
  always @(posedge clk) osc_div <= osc_div + 3'h1;
  // Event counter
  always @(posedge clk) if (ev === 1'b1) n_ev++;

  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    @(posedge clk);
    d = rd_data;
  endtask

  // Write only while the sync flag is low, then let the pipeline settle
  task automatic wr_safe(input logic [31:0] d);
    for (int i = 0; i < 2000 && sync !== 1'b0; i++) @(posedge clk);
    wr_reg(4'h0, d);
    repeat (8) @(posedge clk);
  endtask

  // Reread control until two reads give the same repeat count
  task automatic rd_agree(output logic [31:0] d);
    logic [31:0] prev;
    rd_reg(4'h0, prev);
    rd_reg(4'h0, d);
    for (int i = 0; i < 8 && d[7:0] !== prev[7:0]; i++) begin
      prev = d;
      rd_reg(4'h0, d);
    end
  endtask

  task automatic count_window(input int n);
    n_ev = 0;
    repeat (n) @(posedge clk);
  endtask

  task automatic summarize;
    if (errors == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Watchdog
  initial begin
    repeat (60000) @(posedge clk);
    errors++;
    summarize();
  end

  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd_reg(4'h0, v); `CHK("ctl reset", 32'h0, v)
    wr_reg(4'h4, 32'hffffffff);
    rd_reg(4'h4, v); `CHK("time mask", 32'h3f7f7f00, v)
    wr_reg(4'h0, 32'hffff79ff);
    rd_reg(4'h0, v); `CHK("ctl rw", 32'h000069ff, v)
    `CHK("piv level", 1'b1, pulse)
    wr_reg(4'h8, 32'h0);
    rd_reg(4'h8, v); `CHK("unmapped", 32'h0, v)
    sys_rst_n <= 1'b0;
    @(posedge clk);
    sys_rst_n <= 1'b1;
    rd_reg(4'h0, v); `CHK("sys reset", 32'h000069ff, v)
    wr_reg(4'h0, 32'h0000a000);
    wr_reg(4'h0, 32'h00008000);
    rd_reg(4'h0, v); `CHK("armed piv", 32'h0000a000, v)
    `CHK("armed pulse", 1'b1, pulse)
    wr_reg(4'h0, 32'h0);
    rd_reg(4'h0, v); `CHK("piv kept", 32'h00002000, v)
    wr_reg(4'h0, 32'h0);
    wr_reg(4'h4, 32'h0);
    rd_reg(4'h0, v); `CHK("disarm", 32'h0, v)
    on <= 1'b1;
    // Chime off: two repeats then self-disarm
    wr_safe(32'h00008002);
    count_window(2048);
    `CHK("rpt events", 3, n_ev)
    rd_reg(4'h0, v); `CHK("auto clear", 32'h0, v & 32'hffffefff)
    // Chime on: zero wraps to full count
    wr_safe(32'h0000c000);
    for (int i = 0; i < 1100 && ev !== 1'b1; i++) @(posedge clk);
    rd_agree(v);
    `CHK("chime wrap", 32'h0000e0ff, v & 32'hffffefff)
    // Every interval code matched and with seconds mismatched, then codes 7 to 9 with date inputs split
    for (int m = 0; m < 4; m++) begin
      sec_ones  <= (m == 1) ? 4'h1 : 4'h0;
      wk_match  <= (m != 2);
      day_match <= (m != 3);
      mon_match <= (m != 2);
      for (int c = (m > 1) ? 7 : 0; c < 10; c++) begin
        wr_safe(32'h0000c0ff | (c << 8));
        count_window(1024);
        want = (c == 0) ? 2 : (m == 0 || c == 1) ? 1 : (m == 2) ? int'(c == 8) : int'(m == 3 && c == 7);
        `CHK("interval", want, n_ev)
      end
    end
    on <= 1'b0;
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd_reg(4'h0, v); `CHK("por", 32'h0, v)
    `CHK("por pulse", 1'b0, pulse)
    summarize();
  end
endmodule
